/* fcwl_flash_model.sv */
// Program flash model returning the two configuration words
`timescale 1ns/1ps
module fcwl_flash_model (
	input wire logic i_clk,
	input wire logic i_req,
	input wire logic [23:0] i_addr,
	input wire logic [3:0] i_lat,
	input wire logic [23:0] i_word_one,
	input wire logic [23:0] i_word_two,
	output logic o_ready,
	output logic [23:0] o_rdata
);
	logic [3:0] cnt = 4'h0;
	initial o_ready = 1'b0;
	initial o_rdata = 24'h00_0000;
	// Data toggles whenever no word is returned
	always @(posedge i_clk) begin
		o_ready <= 1'b0;
		o_rdata <= ~o_rdata;
		cnt <= i_req ? cnt + 4'h1 : 4'h0;
		if (i_req && !o_ready && cnt >= i_lat) begin
			o_ready <= 1'b1;
			o_rdata <= (i_addr == 24'h00_ABFE) ? i_word_one : i_word_two;
		end
	end
endmodule : fcwl_flash_model

/* fcwl_loader.sv */
// Flash configuration word loader: fetches both configuration words after every reset and unpacks word one
`timescale 1ns/1ps
module fcwl_loader #(
	parameter int ADDR_W = 24,
	parameter logic [23:0] WORD_ONE_ADDR = fcwl_pkg::FCWL_WORD_ONE_ADDR,
	parameter logic [23:0] WORD_TWO_ADDR = fcwl_pkg::FCWL_WORD_TWO_ADDR
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_flash_ready,
	input wire logic [23:0] i_flash_rdata,
	output logic o_flash_req,
	output logic [ADDR_W-1:0] o_flash_addr,
	output logic o_config_valid,
	output logic o_hold_reset,
	output logic [23:0] o_config_word_one,
	output logic [23:0] o_config_word_two,
	output logic o_scan_port_enable,
	output logic o_code_protect,
	output logic o_write_protect,
	output logic o_debug_mode,
	output logic [1:0] o_emulator_pin_pair_sel,
	output logic o_emulator_pair_reserved,
	output logic o_watchdog_enable,
	output logic o_watchdog_window,
	output logic o_watchdog_config_error,
	output logic [7:0] o_watchdog_prescale_ratio,
	output logic [3:0] o_watchdog_postscale_sel,
	output logic o_reserved_bit_error
);
	// ****************************************
	// Elaboration check
	// ****************************************
	if (ADDR_W != fcwl_pkg::FCWL_WORD_W) begin : g_bad_width
		$error("fcwl_loader supports only a 24-bit flash address");
	end

	// ****************************************
	// Address map checks
	// ****************************************
	// Both words sit in user flash, below the configuration space
	if (WORD_ONE_ADDR >= fcwl_pkg::FCWL_CFG_SPACE_BASE) begin : g_bad_word_one
		$error("fcwl_loader word one address lies in configuration space");
	end
	if (WORD_TWO_ADDR >= fcwl_pkg::FCWL_CFG_SPACE_BASE) begin : g_bad_word_two
		$error("fcwl_loader word two address lies in configuration space");
	end

	// Unpacked settings are mapped inside the configuration space
	if ((fcwl_pkg::FCWL_CFG_MAP_BASE < fcwl_pkg::FCWL_CFG_SPACE_BASE)
		|| (fcwl_pkg::FCWL_CFG_MAP_BASE > fcwl_pkg::FCWL_CFG_SPACE_TOP)) begin : g_bad_map
		$error("fcwl_loader configuration map lies outside configuration space");
	end

	// Word one is the top word, word two the word just below it
	if (WORD_ONE_ADDR <= WORD_TWO_ADDR) begin : g_bad_order
		$error("fcwl_loader word one must lie above word two");
	end

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		fcwl_pkg::fcwl_state_type st;
		logic req;
		logic [23:0] addr;
		logic valid;
		logic hold;
		logic [23:0] w1;
		logic [23:0] w2;
		logic scan_en;
		logic code_prot;
		logic write_prot;
		logic debug;
		logic [1:0] emu_sel;
		logic emu_rsv;
		logic wdt_en;
		logic wdt_win;
		logic wdt_err;
		logic [7:0] pre;
		logic [3:0] post;
		logic rsv_err;
	} fcwl_regs_type;

	fcwl_regs_type r;
	fcwl_regs_type next_r;

	// Force unimplemented positions to read as one
	function automatic logic [23:0] fcwl_fill(input logic [23:0] w);
		fcwl_fill = w | fcwl_pkg::FCWL_UNIMP_MASK;
	endfunction : fcwl_fill

	localparam fcwl_regs_type FCWL_RESET_REGS = '{
		st: fcwl_pkg::FCWL_ST_REQ_ONE,
		req: 1'b0,
		addr: 24'h00_0000,
		valid: 1'b0,
		hold: 1'b1,
		w1: fcwl_pkg::FCWL_ERASED,
		w2: fcwl_pkg::FCWL_ERASED,
		scan_en: 1'b0,
		code_prot: 1'b1,
		write_prot: 1'b1,
		debug: 1'b0,
		emu_sel: fcwl_pkg::FCWL_EMU_NONE,
		emu_rsv: 1'b0,
		wdt_en: 1'b0,
		wdt_win: 1'b0,
		wdt_err: 1'b0,
		pre: fcwl_pkg::FCWL_PRESCALE_HI,
		post: 4'h0,
		rsv_err: 1'b0
	};

	// ****************************************
	// Fetch and unpack
	// ****************************************
	always_comb begin
		logic [23:0] w;
		w = fcwl_fill(r.w1);
		next_r = r;
		next_r.req = 1'b0;
		case (r.st)
			fcwl_pkg::FCWL_ST_REQ_ONE: begin
				next_r.req = 1'b1;
				next_r.addr = WORD_ONE_ADDR;
				next_r.st = fcwl_pkg::FCWL_ST_WAIT_ONE;
			end
			fcwl_pkg::FCWL_ST_WAIT_ONE: begin
				next_r.req = ~i_flash_ready;
				if (i_flash_ready) begin
					next_r.w1 = fcwl_fill(i_flash_rdata);
					next_r.st = fcwl_pkg::FCWL_ST_REQ_TWO;
				end
			end
			fcwl_pkg::FCWL_ST_REQ_TWO: begin
				next_r.req = 1'b1;
				next_r.addr = WORD_TWO_ADDR;
				next_r.st = fcwl_pkg::FCWL_ST_WAIT_TWO;
			end
			fcwl_pkg::FCWL_ST_WAIT_TWO: begin
				next_r.req = ~i_flash_ready;
				if (i_flash_ready) begin
					// Upper byte of word two is unimplemented and reads as one
					next_r.w2 = i_flash_rdata | (fcwl_pkg::FCWL_ERASED & 24'hFF_0000);
					next_r.scan_en = w[fcwl_pkg::FCWL_SCAN_EN_BIT];
					next_r.code_prot = ~w[fcwl_pkg::FCWL_CODE_PROT_BIT];
					next_r.write_prot = ~w[fcwl_pkg::FCWL_WRITE_PROT_BIT];
					next_r.debug = ~w[fcwl_pkg::FCWL_DEBUG_BIT];
					next_r.emu_sel = w[fcwl_pkg::FCWL_EMU_SEL_LSB +: 2];
					next_r.emu_rsv = (w[fcwl_pkg::FCWL_EMU_SEL_LSB +: 2] == fcwl_pkg::FCWL_EMU_RESERVED);
					next_r.wdt_en = w[fcwl_pkg::FCWL_WDT_EN_BIT];
					next_r.wdt_win = ~w[fcwl_pkg::FCWL_WIN_DIS_BIT] & w[fcwl_pkg::FCWL_WDT_EN_BIT];
					next_r.wdt_err = ~w[fcwl_pkg::FCWL_WIN_DIS_BIT] & ~w[fcwl_pkg::FCWL_WDT_EN_BIT];
					next_r.pre = w[fcwl_pkg::FCWL_PRESCALE_BIT] ? fcwl_pkg::FCWL_PRESCALE_HI
						: fcwl_pkg::FCWL_PRESCALE_LO;
					next_r.post = w[fcwl_pkg::FCWL_POSTSCALE_LSB +: 4];
					next_r.rsv_err = w[fcwl_pkg::FCWL_RSV15_BIT] | ~w[fcwl_pkg::FCWL_RSV10_BIT];
					next_r.st = fcwl_pkg::FCWL_ST_DONE;
				end
			end
			fcwl_pkg::FCWL_ST_DONE: begin
				next_r.valid = 1'b1;
				next_r.hold = 1'b0;
			end
			default: begin
				next_r = FCWL_RESET_REGS;
			end
		endcase
	end

	// Every reset restarts the fetch; nothing survives it
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			r <= FCWL_RESET_REGS;
		end else begin
			r <= next_r;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign o_flash_req = r.req;
	assign o_flash_addr = r.addr;
	assign o_config_valid = r.valid;
	assign o_hold_reset = r.hold;
	assign o_config_word_one = r.w1;
	assign o_config_word_two = r.w2;
	assign o_scan_port_enable = r.scan_en;
	assign o_code_protect = r.code_prot;
	assign o_write_protect = r.write_prot;
	assign o_debug_mode = r.debug;
	assign o_emulator_pin_pair_sel = r.emu_sel;
	assign o_emulator_pair_reserved = r.emu_rsv;
	assign o_watchdog_enable = r.wdt_en;
	assign o_watchdog_window = r.wdt_win;
	assign o_watchdog_config_error = r.wdt_err;
	assign o_watchdog_prescale_ratio = r.pre;
	assign o_watchdog_postscale_sel = r.post;
	assign o_reserved_bit_error = r.rsv_err;
endmodule : fcwl_loader

/* fcwl_loader_assertions.sv */
// Checker of the configuration loader outputs
`timescale 1ns/1ps
module fcwl_chk (
	input logic i_clk,
	input logic i_rst,
	input logic o_flash_req,
	input logic [23:0] o_flash_addr,
	input logic o_config_valid,
	input logic o_hold_reset,
	input logic [23:0] o_config_word_one,
	input logic o_scan_port_enable,
	input logic o_code_protect,
	input logic o_write_protect,
	input logic o_debug_mode,
	input logic [1:0] o_emulator_pin_pair_sel,
	input logic o_emulator_pair_reserved,
	input logic o_watchdog_enable,
	input logic o_watchdog_window,
	input logic [7:0] o_watchdog_prescale_ratio,
	input logic [3:0] o_watchdog_postscale_sel,
	input logic o_watchdog_config_error,
	input logic o_reserved_bit_error,
	input logic [23:0] o_config_word_two
);
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	wire v = o_config_valid;
	wire [23:0] w = o_config_word_one;
	chk_hold_until_valid: assert property (o_hold_reset == !v)
		else $error("hold and valid disagree");
	chk_config_stays: assert property (v |=> v && $stable(w))
		else $error("loaded word changed");
	chk_fetch_addr: assert property (o_flash_req |-> o_flash_addr inside {24'h00_ABFE, 24'h00_ABFC})
		else $error("fetch address wrong");
	chk_unimpl_ones: assert property (v |-> &(w | ~24'hFF_0020))
		else $error("unimplemented bit low");
	chk_scan_debug: assert property (v |-> o_scan_port_enable == w[14] && o_debug_mode == !w[11])
		else $error("scan or debug decode");
	chk_protect_bits: assert property (v |-> o_code_protect == !w[13] && o_write_protect == !w[12])
		else $error("protect decode");
	chk_emulator_pair: assert property (v |-> o_emulator_pin_pair_sel == w[9:8]
		&& o_emulator_pair_reserved == (w[9:8] == 2'h0)) else $error("emulator decode");
	chk_watchdog_mode: assert property (v |-> o_watchdog_enable == w[7] && o_watchdog_window == (w[7] && !w[6]))
		else $error("watchdog mode decode");
	chk_watchdog_scale: assert property (v |-> o_watchdog_postscale_sel == w[3:0]
		&& o_watchdog_prescale_ratio == (w[4] ? 8'h80 : 8'h20)) else $error("watchdog scale decode");
	chk_window_error: assert property (v |-> o_watchdog_config_error == (!w[7] && !w[6]))
		else $error("watchdog window error flag wrong");
	chk_reserved_flag: assert property (v |-> o_reserved_bit_error == (w[15] || !w[10]))
		else $error("reserved bit flag wrong");
	chk_word_two_upper: assert property (v |-> o_config_word_two[23:16] == 8'hFF)
		else $error("word two upper byte low");
endmodule : fcwl_chk
bind fcwl_loader fcwl_chk i_chk (
	.i_clk(i_clk),
	.i_rst(i_rst),
	.o_flash_req(o_flash_req),
	.o_flash_addr(o_flash_addr),
	.o_config_valid(o_config_valid),
	.o_hold_reset(o_hold_reset),
	.o_config_word_one(o_config_word_one),
	.o_scan_port_enable(o_scan_port_enable),
	.o_code_protect(o_code_protect),
	.o_write_protect(o_write_protect),
	.o_debug_mode(o_debug_mode),
	.o_emulator_pin_pair_sel(o_emulator_pin_pair_sel),
	.o_emulator_pair_reserved(o_emulator_pair_reserved),
	.o_watchdog_enable(o_watchdog_enable),
	.o_watchdog_window(o_watchdog_window),
	.o_watchdog_prescale_ratio(o_watchdog_prescale_ratio),
	.o_watchdog_postscale_sel(o_watchdog_postscale_sel),
	.o_watchdog_config_error(o_watchdog_config_error),
	.o_reserved_bit_error(o_reserved_bit_error),
	.o_config_word_two(o_config_word_two)
);

/* fcwl_pkg.sv */
// Package of constants and types for the flash configuration word loader
package fcwl_pkg;
	// ****************************************
	// Flash layout
	// ****************************************
	localparam logic [23:0] FCWL_CFG_SPACE_BASE = 24'h80_0000;
	localparam logic [23:0] FCWL_CFG_SPACE_TOP = 24'hFF_FFFF;
	localparam logic [23:0] FCWL_CFG_MAP_BASE = 24'hF8_0000;
	localparam logic [23:0] FCWL_WORD_ONE_ADDR = 24'h00_ABFE;
	localparam logic [23:0] FCWL_WORD_TWO_ADDR = 24'h00_ABFC;
	localparam int FCWL_WORD_W = 24;
	// ****************************************
	// Word one field positions
	// ****************************************
	localparam int FCWL_RSV15_BIT = 15;
	localparam int FCWL_SCAN_EN_BIT = 14;
	localparam int FCWL_CODE_PROT_BIT = 13;
	localparam int FCWL_WRITE_PROT_BIT = 12;
	localparam int FCWL_DEBUG_BIT = 11;
	localparam int FCWL_RSV10_BIT = 10;
	localparam int FCWL_EMU_SEL_LSB = 8;
	localparam int FCWL_WDT_EN_BIT = 7;
	localparam int FCWL_WIN_DIS_BIT = 6;
	localparam int FCWL_UNIMP5_BIT = 5;
	localparam int FCWL_PRESCALE_BIT = 4;
	localparam int FCWL_POSTSCALE_LSB = 0;
	// Upper byte and bit 5 are unimplemented and read as one
	localparam logic [23:0] FCWL_UNIMP_MASK = 24'hFF_0020;
	localparam logic [23:0] FCWL_ERASED = 24'hFF_FFFF;
	// Prescaler ratios
	localparam logic [7:0] FCWL_PRESCALE_HI = 8'h80;
	localparam logic [7:0] FCWL_PRESCALE_LO = 8'h20;
	// Emulator pin pair codes
	localparam logic [1:0] FCWL_EMU_PAIR_ONE = 2'h3;
	localparam logic [1:0] FCWL_EMU_PAIR_TWO = 2'h2;
	localparam logic [1:0] FCWL_EMU_PAIR_THREE = 2'h1;
	localparam logic [1:0] FCWL_EMU_RESERVED = 2'h0;
	localparam logic [1:0] FCWL_EMU_NONE = 2'h0;
	// ****************************************
	// Loader states
	// ****************************************
	typedef enum logic [4:0] {
		FCWL_ST_REQ_ONE = 5'b00001,
		FCWL_ST_WAIT_ONE = 5'b00010,
		FCWL_ST_REQ_TWO = 5'b00100,
		FCWL_ST_WAIT_TWO = 5'b01000,
		FCWL_ST_DONE = 5'b10000
	} fcwl_state_type;
endpackage : fcwl_pkg

/* test_flash_config_word_loader.sv */
// Testbench of the configuration loader
`timescale 1ns/1ps
module test_flash_config_word_loader;
	logic i_clk = 1'b0, i_rst = 1'b1, i_flash_ready, o_flash_req, o_config_valid, o_hold_reset;
	logic o_scan_port_enable, o_code_protect, o_write_protect, o_debug_mode, o_emulator_pair_reserved;
	logic o_watchdog_enable, o_watchdog_window, o_watchdog_config_error, o_reserved_bit_error;
	logic [1:0] o_emulator_pin_pair_sel;
	logic [3:0] o_watchdog_postscale_sel, lat = 4'h0;
	logic [7:0] o_watchdog_prescale_ratio;
	logic [23:0] i_flash_rdata, o_flash_addr, o_config_word_one, o_config_word_two, w, img = 24'hFF_FFFF;
	logic [23:0] imgs [4] = '{24'hFF_FFFF, 24'hFF_0490, 24'h00_4E40, 24'hFF_3D07};
	int err_total = 0, compares = 0;
	fcwl_loader i_dut (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_flash_ready(i_flash_ready),
		.i_flash_rdata(i_flash_rdata),
		.o_flash_req(o_flash_req),
		.o_flash_addr(o_flash_addr),
		.o_config_valid(o_config_valid),
		.o_hold_reset(o_hold_reset),
		.o_config_word_one(o_config_word_one),
		.o_config_word_two(o_config_word_two),
		.o_scan_port_enable(o_scan_port_enable),
		.o_code_protect(o_code_protect),
		.o_write_protect(o_write_protect),
		.o_debug_mode(o_debug_mode),
		.o_emulator_pin_pair_sel(o_emulator_pin_pair_sel),
		.o_emulator_pair_reserved(o_emulator_pair_reserved),
		.o_watchdog_enable(o_watchdog_enable),
		.o_watchdog_window(o_watchdog_window),
		.o_watchdog_config_error(o_watchdog_config_error),
		.o_watchdog_prescale_ratio(o_watchdog_prescale_ratio),
		.o_watchdog_postscale_sel(o_watchdog_postscale_sel),
		.o_reserved_bit_error(o_reserved_bit_error)
	);
	fcwl_flash_model i_flash (.i_clk, .i_req(o_flash_req), .i_addr(o_flash_addr), .i_lat(lat), .i_word_one(img),
		.i_word_two(24'h12_3456), .o_ready(i_flash_ready), .o_rdata(i_flash_rdata));
	initial forever #5 i_clk = ~i_clk;
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic close_out;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : close_out
	initial begin
		#20000;
		err_total++;
		close_out();
	end
	initial begin
		for (int k = 0; k < 4; k++) begin
			@(posedge i_clk);
			#1 i_rst = 1'b1;
			img = imgs[k];
			lat = k[3:0];
			repeat (4) @(posedge i_clk);
			#1 chk(o_hold_reset, 1'b1);
			chk(o_config_valid, 1'b0);
			i_rst = 1'b0;
			for (int n = 0; n < 40 && o_config_valid !== 1'b1; n++) begin
				@(posedge i_clk);
				#1;
			end
			#1 w = img | 24'hFF_0020;
			chk(o_hold_reset, 1'b0);
			chk(o_config_word_one, w);
			chk(o_config_word_two, 24'hFF_3456);
			chk(o_scan_port_enable, w[14]);
			chk(o_code_protect, !w[13]);
			chk(o_write_protect, !w[12]);
			chk(o_debug_mode, !w[11]);
			chk(o_emulator_pin_pair_sel, w[9:8]);
			chk(o_emulator_pair_reserved, w[9:8] == 2'h0);
			chk(o_watchdog_enable, w[7]);
			chk(o_watchdog_window, w[7] && !w[6]);
			chk(o_watchdog_config_error, !w[7] && !w[6]);
			chk(o_watchdog_prescale_ratio, w[4] ? 8'h80 : 8'h20);
			chk(o_watchdog_postscale_sel, w[3:0]);
			chk(o_reserved_bit_error, w[15] || !w[10]);
		end
		close_out();
	end
endmodule : test_flash_config_word_loader
